// ==== bench/pia_partner.sv ====
// Link partner model: hears the word offered at each restart
`timescale 1ns/100ps
module pia_partner (input wire logic CLOCK, RESTART_PULSE, input wire logic [15:0] ADVERTISED_WORD,
  output logic [15:0] heard);
  always @(posedge CLOCK) if (RESTART_PULSE) heard <= ADVERTISED_WORD;
endmodule // pia_partner

// ==== bench/pia_properties.sv ====
// Port assertions for the identifier and advertisement bank
`timescale 1ns/100ps
module pia_chk (input wire logic CLOCK, RESET_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR,
  input wire logic RESTART_PULSE, input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA, PRDATA, input wire logic [15:0] ADVERTISED_WORD);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  sequence s_wr(a); PSEL && PENABLE && PWRITE && PADDR == a; endsequence
  sequence s_rd(a); PSEL && !PENABLE && !PWRITE && PADDR == a; endsequence
  wire logic go = PSEL && PENABLE && PWRITE && PADDR == 8'h00 && PWDATA[9];
  a_id_ok: assert property (PSEL && PENABLE && PADDR inside {8'h08, 8'h0C}
    |-> PREADY && !PSLVERR) else $error("id refused");
  a_sel_fixed: assert property (s_rd(8'h10) |=> PRDATA[4:0] == 5'h01)
    else $error("bad selector");
  a_rsvd_zero: assert property (s_rd(8'h10) |=> {PRDATA[15:14], PRDATA[12:9]} == 0)
    else $error("reserved set");
  a_adv_write: assert property (s_wr(8'h10) ##2 s_rd(8'h10)
    |=> PRDATA[8:5] == $past(PWDATA[8:5], 3)) else $error("ability lost");
  a_word_hold: assert property (!go |=> $stable(ADVERTISED_WORD))
    else $error("word moved");
  a_pulse_cause: assert property (go |=> RESTART_PULSE)
    else $error("no pulse");
  a_pulse_once: assert property (RESTART_PULSE |=> !RESTART_PULSE)
    else $error("long pulse");
  a_reset_adv: assert property ($rose(RESET_N) |-> ADVERTISED_WORD == 16'h01E1)
    else $error("bad reset word");
endmodule // pia_chk
bind pia_regbank pia_chk C (.*);

// ==== bench/tb_top.sv ====
// Self-checking bench for the identifier and advertisement bank
`timescale 1ns/100ps
module tb_top;
  localparam MK = 22'h15A5A5, MD = 6'h2C, RV = 4'h9; // Arbitrary identity values
  logic CLOCK = 0, RESET_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, PREADY, PSLVERR, err;
  logic RESTART_PULSE;
  logic [7:0] PADDR = 0;
  logic [31:0] PWDATA = 0, PRDATA, rd;
  logic [15:0] ADVERTISED_WORD, heard;
  int n_mismatch = 0, n_checks = 0;
  pia_regbank #(.OUI_VALUE(MK), .MODEL_VALUE(MD), .REV_VALUE(RV)) DUT (.*);
  pia_partner LP (.*);
  always #2.5 CLOCK = ~CLOCK;
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK) {PSEL, PWRITE, PADDR, PWDATA} <= {1'b1, w, a, d};
    @(posedge CLOCK) PENABLE <= 1;
    do @(posedge CLOCK); while (PREADY !== 1'b1);
    {rd, err} = {PRDATA, PSLVERR};
    {PSEL, PENABLE} <= 2'b00;
  endtask
  task chk(input string n, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin n_mismatch++; $display("ERROR %s exp %h got %h", n, e, g); end
  endtask
  task t_adv;
    apb(0, 8'h10, 0);
    chk("adv", 16'h01E1, rd);
    apb(1, 8'h10, '1);
    apb(0, 8'h10, 0);
    chk("adv", 16'h21E1, rd);
    chk("word", 16'h01E1, ADVERTISED_WORD);
    apb(0, 8'h14, 0);
    chk("active", 16'h01E1, rd);
    for (int i = 5; i < 9; i++) begin
      apb(1, 8'h10, 32'h2000 | 32'h1 << i);
      apb(1, 8'h00, 32'h200);
      repeat (3) @(posedge CLOCK);
      chk("heard", 16'h2001 | 16'h1 << i, heard);
    end
    $display("adv test done");
  endtask
  task t_ident;
    apb(1, 8'h08, '1);
    apb(1, 8'h0C, '1);
    apb(0, 8'h08, 0);
    chk("id high", MK[21:6], rd);
    apb(0, 8'h0C, 0);
    chk("id low", {MK[5:0], MD, RV}, rd);
    apb(1, 8'h18, '1);
    chk("unmapped", 1, err);
    apb(0, 8'h09, 0);
    chk("misaligned", 1, err);
    chk("misaligned data", 0, rd);
    $display("ident test done");
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #20000 n_mismatch++;
    final_report;
  end
  initial begin
    repeat (6) @(posedge CLOCK);
    RESET_N <= 1;
    t_adv;
    t_ident;
    final_report;
  end
endmodule // tb_top

// ==== core/pia_ident.v ====
// Read-only identifier word builder
`timescale 1ns/100ps
module pia_ident #(
  parameter [21:0] OUI_VALUE   = 22'h2A5A5A, // Arbitrary value
  parameter [5:0]  MODEL_VALUE = 6'h15,      // Arbitrary value
  parameter [3:0]  REV_VALUE   = 4'h3        // Arbitrary value
) (
  output wire [15:0] id_high,
  output wire [15:0] id_low
);
  // High word carries maker bits 21..6, low word maker bits 5..0
  assign id_high = OUI_VALUE[21:6];
  assign id_low  = {OUI_VALUE[5:0], MODEL_VALUE, REV_VALUE};
endmodule // pia_ident

// ==== core/pia_regbank.v ====
// APB register bank: PHY identifier and negotiation advertisement
//
// Summary of operation
// - 32-bit id spans two identifier registers
// - Maker id split across both registers
// - Low four bits hold revision
// - Identifiers read-only at 0x02, 0x03
// - New advertisement used only after restart
// - Bits 8:5 are writable ability bits
// - Advertisement at 0x04, resets 0x01E1
// - Selector bits 4:0 fixed 0x01
`timescale 1ns/100ps
`include "pia_regs.vh"
module pia_regbank #(
  parameter [21:0] OUI_VALUE   = 22'h2A5A5A, // Arbitrary value
  parameter [5:0]  MODEL_VALUE = 6'h15,      // Arbitrary value
  parameter [3:0]  REV_VALUE   = 4'h3        // Arbitrary value
) (
  input  wire        CLOCK,
  input  wire        RESET_N,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [7:0]  PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output wire        PREADY,
  output wire        PSLVERR,
  output reg  [15:0] ADVERTISED_WORD,
  output reg         RESTART_PULSE
);

  // --------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------
  wire        access   = PSEL & PENABLE;
  wire [4:0]  index    = PADDR[6:2];
  wire        aligned  = (PADDR[1:0] == 2'h0) & ~PADDR[7];
  wire        do_write = access & PWRITE;

  function mapped;
    input [4:0] idx;
    begin
      mapped = (idx == `PIA_IDX_CONTROL) | (idx == `PIA_IDX_ID_HIGH) |
               (idx == `PIA_IDX_ID_LOW) | (idx == `PIA_IDX_ADVERTISE) |
               (idx == `PIA_IDX_ADV_ACTIVE);
    end
  endfunction

  function hit;
    input [4:0] idx;
    input [4:0] want;
    input       ok;
    begin
      hit = ok & (idx == want);
    end
  endfunction

  // Zero wait states; unmapped addresses answer with an error
  assign PREADY  = 1'b1;
  assign PSLVERR = access & ~(aligned & mapped(index));

  // --------------------------------------------------------------
  // Identifier registers
  // --------------------------------------------------------------
  wire [15:0] id_high;
  wire [15:0] id_low;

  pia_ident #(
    .OUI_VALUE   (OUI_VALUE),
    .MODEL_VALUE (MODEL_VALUE),
    .REV_VALUE   (REV_VALUE)
  ) u_ident (
    .id_high (id_high),
    .id_low  (id_low)
  );

  // --------------------------------------------------------------
  // Advertisement register
  // --------------------------------------------------------------
  reg  [3:0] abilities;
  reg        remote_fault_flag;
  wire [15:0] negotiation_advertisement;

  // Selector hard-wired, next page and reserved bits tied low
  assign negotiation_advertisement = {1'b0, 1'b0, remote_fault_flag, 4'h0,
                                      abilities, `PIA_ADV_SELECTOR};

  wire adv_write = do_write & hit(index, `PIA_IDX_ADVERTISE, aligned);
  wire restart   = do_write & hit(index, `PIA_IDX_CONTROL, aligned) &
                   PWDATA[`PIA_CTRL_RESTART];

  always @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      abilities         <= `PIA_ADV_ABIL_RESET;
      remote_fault_flag <= 1'b0;
    end else if (adv_write) begin
      abilities         <= PWDATA[`PIA_ADV_ABIL_MSB:`PIA_ADV_ABIL_LSB];
      remote_fault_flag <= PWDATA[`PIA_ADV_REMOTE_FAULT];
    end
  end

  // --------------------------------------------------------------
  // Word handed to the negotiation engine
  // --------------------------------------------------------------
  // Stored value is only latched on restart, so software may edit
  // several bits without the partner seeing a half-done word.
  always @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      ADVERTISED_WORD <= `PIA_ADV_RESET;
      RESTART_PULSE   <= 1'b0;
    end else begin
      RESTART_PULSE <= restart;
      if (restart) begin
        ADVERTISED_WORD <= negotiation_advertisement;
      end
    end
  end

  // --------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------
  reg [15:0] next_rdata;

  always @* begin
    next_rdata = 16'h0000;
    if (aligned) begin
      case (index)
        `PIA_IDX_ID_HIGH:    next_rdata = id_high;
        `PIA_IDX_ID_LOW:     next_rdata = id_low;
        `PIA_IDX_ADVERTISE:  next_rdata = negotiation_advertisement;
        `PIA_IDX_ADV_ACTIVE: next_rdata = ADVERTISED_WORD;
        default:             next_rdata = 16'h0000;
      endcase
    end
  end

  // Registered read data, updated in setup phase so valid in access phase
  always @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      PRDATA <= 32'h00000000;
    end else if (PSEL & ~PENABLE & ~PWRITE) begin
      PRDATA <= {16'h0000, next_rdata};
    end
  end

endmodule // pia_regbank

// ==== core/pia_regs.vh ====
// Register offsets, field positions and reset values of the identifier and advertisement bank
`ifndef PIA_REGS_VH
`define PIA_REGS_VH

// Management register indices; byte address is index times four
`define PIA_IDX_CONTROL      5'h00
`define PIA_IDX_ID_HIGH      5'h02
`define PIA_IDX_ID_LOW       5'h03
`define PIA_IDX_ADVERTISE    5'h04
`define PIA_IDX_ADV_ACTIVE   5'h05

// Identifier layout
`define PIA_REV_MSB          3
`define PIA_REV_LSB          0
`define PIA_MODEL_MSB        9
`define PIA_MODEL_LSB        4
`define PIA_OUI_LOW_MSB      15
`define PIA_OUI_LOW_LSB      10

// Advertisement layout
`define PIA_ADV_NEXT_PAGE    15
`define PIA_ADV_REMOTE_FAULT 13
`define PIA_ADV_ABIL_MSB     8
`define PIA_ADV_ABIL_LSB     5
`define PIA_ADV_SEL_MSB      4
`define PIA_ADV_SEL_LSB      0
`define PIA_ADV_RESET        16'h01E1
`define PIA_ADV_SELECTOR     5'h01
`define PIA_ADV_ABIL_RESET   4'hF
`define PIA_ADV_WMASK        16'h21E0

// Control register restart bit
`define PIA_CTRL_RESTART     9

`endif
